/* core/tsr_pkg.sv */
package tsr_pkg;
  // ****************************************************************
  // command codes
  // ****************************************************************
  localparam logic [7:0] CMD_FAULT_CLEAR = 8'h03;
  localparam logic [7:0] CMD_VENDOR_STATUS = 8'h80;
  localparam logic [7:0] CMD_INPUT_VOLTAGE = 8'h88;
  localparam logic [7:0] CMD_INPUT_CURRENT = 8'h89;
  localparam logic [7:0] CMD_OUTPUT_VOLTAGE = 8'h8B;
  localparam logic [7:0] CMD_OUTPUT_CURRENT = 8'h8C;

  // ****************************************************************
  // status bit positions and reset values
  // ****************************************************************
  localparam int BIT_NO_OP_CYCLE = 2;
  localparam int BIT_STAGE_OVERTEMP = 1;
  localparam int BIT_DRIVER_SUPPLY_UV = 0;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] READING_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_HZ = 20_000_000;
  localparam int SLOW_REFRESH_US = 190;
  localparam int FAST_REFRESH_US = 95;
  localparam int SLOW_REFRESH_CYC = SLOW_REFRESH_US * (CLK_HZ / 1_000_000);
  localparam int FAST_REFRESH_CYC = FAST_REFRESH_US * (CLK_HZ / 1_000_000);
  localparam int TICK_W = 12;

  // ****************************************************************
  // voltage step selection
  // ****************************************************************
  typedef enum logic [0:0] {
    TSR_STEP_5MV = 1'b0,
    TSR_STEP_10MV = 1'b1
  } tsr_step_e;
endpackage : tsr_pkg

/* core/tsr_refresh_tick.sv */
`timescale 1ns/1ps
`default_nettype none
module tsr_refresh_tick #(
  parameter int PERIOD = 3800
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  output logic tick_o
);
  import tsr_pkg::*;

  logic [TICK_W-1:0] cnt_r;
  logic [TICK_W-1:0] cnt_nxt;
  logic tick_r;
  logic tick_nxt;

  localparam logic [TICK_W-1:0] LAST = TICK_W'(PERIOD - 1);

  always_comb begin
    tick_nxt = 1'b0;
    cnt_nxt = cnt_r + 1'b1;
    if (cnt_r == LAST) begin
      cnt_nxt = '0;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick_o = tick_r;
endmodule : tsr_refresh_tick
`default_nettype wire

/* core/tsr_telemetry_status_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module tsr_telemetry_status_regs (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // command port from the serial interface
  input wire logic [7:0] cmd_code_i,
  input wire logic rd_strobe_i,
  input wire logic wr_strobe_i,
  input wire logic send_byte_i,
  input wire logic [7:0] wr_data_i,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  // fault events and comparators
  input wire logic no_op_cycle_i,
  input wire logic stage_overtemp_i,
  input wire logic driver_supply_uv_i,
  // converter samples
  input wire logic [7:0] vin_sample_i,
  input wire logic [7:0] iin_sample_i,
  input wire logic [8:0] vout_sample_i,
  input wire logic [7:0] iout_sample_i,
  input wire tsr_pkg::tsr_step_e vout_step_i,
  output logic [7:0] vendor_fault_status_o
);
  import tsr_pkg::*;

  // ****************************************************************
  // refresh timebases
  // ****************************************************************
  logic slow_tick;
  logic fast_tick;

  tsr_refresh_tick #(.PERIOD(SLOW_REFRESH_CYC)) u_slow_tick (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .tick_o(slow_tick)
  );

  tsr_refresh_tick #(.PERIOD(FAST_REFRESH_CYC)) u_fast_tick (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .tick_o(fast_tick)
  );

  // ****************************************************************
  // telemetry holding registers
  // ****************************************************************
  logic [7:0] vin_r;
  logic [7:0] vin_nxt;
  logic [7:0] iin_r;
  logic [7:0] iin_nxt;
  logic [7:0] vout_r;
  logic [7:0] vout_nxt;
  logic [7:0] iout_r;
  logic [7:0] iout_nxt;
  logic [7:0] vout_scaled;

  always_comb begin
    // 10 mV step halves resolution; 5 mV keeps low byte, clipped to range
    if (vout_step_i == TSR_STEP_10MV) begin
      vout_scaled = vout_sample_i[8:1];
    end else begin
      vout_scaled = vout_sample_i[8] ? 8'hFF : vout_sample_i[7:0];
    end
  end

  // slow pair: input and output voltage
  always_comb begin
    vin_nxt = vin_r;
    vout_nxt = vout_r;
    // whole byte loaded on one edge; a read sees old or new, never both
    if (slow_tick) begin
      vin_nxt = vin_sample_i;
      vout_nxt = vout_scaled;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      vin_r <= READING_RESET;
      vout_r <= READING_RESET;
    end else begin
      vin_r <= vin_nxt;
      vout_r <= vout_nxt;
    end
  end

  // fast pair: input and output current
  always_comb begin
    iin_nxt = iin_r;
    iout_nxt = iout_r;
    if (fast_tick) begin
      iin_nxt = iin_sample_i;
      iout_nxt = iout_sample_i;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      iin_r <= READING_RESET;
      iout_r <= READING_RESET;
    end else begin
      iin_r <= iin_nxt;
      iout_r <= iout_nxt;
    end
  end

  // ****************************************************************
  // vendor fault status
  // ****************************************************************
  logic noc_r;
  logic noc_nxt;
  logic uv_r;
  logic uv_nxt;
  logic ot_r;
  logic ot_nxt;
  logic clr_all;
  logic wr_status;

  always_comb begin
    clr_all = send_byte_i && (cmd_code_i == CMD_FAULT_CLEAR);
    wr_status = wr_strobe_i && (cmd_code_i == CMD_VENDOR_STATUS);
    noc_nxt = noc_r;
    uv_nxt = uv_r;
    if (clr_all || (wr_status && wr_data_i[BIT_NO_OP_CYCLE])) begin
      noc_nxt = 1'b0;
    end
    if (clr_all || (wr_status && wr_data_i[BIT_DRIVER_SUPPLY_UV])) begin
      uv_nxt = 1'b0;
    end
    // set after clear: an event in the clear cycle survives
    if (no_op_cycle_i) begin
      noc_nxt = 1'b1;
    end
    if (driver_supply_uv_i) begin
      uv_nxt = 1'b1;
    end
    ot_nxt = stage_overtemp_i;
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      noc_r <= STATUS_RESET[BIT_NO_OP_CYCLE];
      uv_r <= STATUS_RESET[BIT_DRIVER_SUPPLY_UV];
      ot_r <= STATUS_RESET[BIT_STAGE_OVERTEMP];
    end else begin
      noc_r <= noc_nxt;
      uv_r <= uv_nxt;
      ot_r <= ot_nxt;
    end
  end

  // ****************************************************************
  // read port
  // ****************************************************************
  logic [7:0] status_now;
  logic [7:0] rd_data_r;
  logic [7:0] rd_data_nxt;
  logic rd_valid_r;
  logic rd_valid_nxt;
  logic [7:0] status_r;

  always_comb begin
    status_now = STATUS_RESET;
    status_now[BIT_NO_OP_CYCLE] = noc_r;
    status_now[BIT_STAGE_OVERTEMP] = ot_r;
    status_now[BIT_DRIVER_SUPPLY_UV] = uv_r;
  end

  always_comb begin
    rd_valid_nxt = rd_strobe_i;
    rd_data_nxt = rd_data_r;
    if (rd_strobe_i) begin
      case (cmd_code_i)
        CMD_VENDOR_STATUS: rd_data_nxt = status_now;
        CMD_INPUT_VOLTAGE: rd_data_nxt = vin_r;
        CMD_INPUT_CURRENT: rd_data_nxt = iin_r;
        CMD_OUTPUT_VOLTAGE: rd_data_nxt = vout_r;
        CMD_OUTPUT_CURRENT: rd_data_nxt = iout_r;
        default: rd_data_nxt = UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_data_r <= READING_RESET;
      rd_valid_r <= 1'b0;
      status_r <= STATUS_RESET;
    end else begin
      rd_data_r <= rd_data_nxt;
      rd_valid_r <= rd_valid_nxt;
      status_r <= status_now;
    end
  end

  assign rd_data_o = rd_data_r;
  assign rd_valid_o = rd_valid_r;
  assign vendor_fault_status_o = status_r;
endmodule : tsr_telemetry_status_regs
`default_nettype wire

/* verification/tsr_chk_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// port checks
// ****
module tsr_chk (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic rd_strobe_i,
  input wire logic wr_strobe_i,
  input wire logic send_byte_i,
  input wire logic [7:0] wr_data_i,
  input wire logic [7:0] rd_data_o,
  input wire logic rd_valid_o,
  input wire logic no_op_cycle_i,
  input wire logic stage_overtemp_i,
  input wire logic driver_supply_uv_i,
  input wire logic [7:0] vendor_fault_status_o
);
  import tsr_pkg::*;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  // status output trails the internal byte by one cycle
  wire logic [7:0] st = vendor_fault_status_o;
  AST_RD_VALID: assert property (rd_strobe_i |=> rd_valid_o) else $error("no read valid");
  AST_NO_OP: assert property (no_op_cycle_i |-> ##2 st[2]) else $error("no-op not set");
  AST_UV: assert property (driver_supply_uv_i |-> ##2 st[0]) else $error("uv not set");
  AST_OT: assert property ($past(reset_n_i, 2) && $past(reset_n_i) |->
    st[1] == $past(stage_overtemp_i, 2)) else $error("overtemp not live");
  AST_CLEAR: assert property (send_byte_i && cmd_code_i == CMD_FAULT_CLEAR &&
    !no_op_cycle_i && !driver_supply_uv_i |-> ##2 !st[2] && !st[0])
    else $error("clear failed");
  AST_W1C: assert property (wr_strobe_i && cmd_code_i == CMD_VENDOR_STATUS &&
    wr_data_i[0] && !driver_supply_uv_i |-> ##2 !st[0]) else $error("write-one failed");
  AST_STICKY: assert property (st[2] && !$past(send_byte_i) &&
    !$past(wr_strobe_i) |=> st[2]) else $error("no-op flag lost");
  AST_STATUS_RD: assert property (rd_strobe_i && cmd_code_i == CMD_VENDOR_STATUS |=>
    rd_data_o == st) else $error("status read differs");
endmodule : tsr_chk
bind tsr_telemetry_status_regs tsr_chk u_chk (
  .mclk_i(mclk_i),
  .reset_n_i(reset_n_i),
  .cmd_code_i(cmd_code_i),
  .rd_strobe_i(rd_strobe_i),
  .wr_strobe_i(wr_strobe_i),
  .send_byte_i(send_byte_i),
  .wr_data_i(wr_data_i),
  .rd_data_o(rd_data_o),
  .rd_valid_o(rd_valid_o),
  .no_op_cycle_i(no_op_cycle_i),
  .stage_overtemp_i(stage_overtemp_i),
  .driver_supply_uv_i(driver_supply_uv_i),
  .vendor_fault_status_o(vendor_fault_status_o)
);
`default_nettype wire

/* verification/tsr_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// host side of the command port
// ****
module tsr_host_model (
  input wire logic mclk_i,
  input wire logic [7:0] rd_data_i,
  input wire logic rd_valid_i,
  output logic [7:0] cmd_o,
  output logic rd_o,
  output logic wr_o,
  output logic send_o,
  output logic [7:0] data_o
);
  initial {cmd_o, rd_o, wr_o, send_o, data_o} = '0;
  // one whole byte per request; k is {read, write, send}
  task automatic issue(input logic [7:0] c, input logic [7:0] d, input logic [2:0] k,
    output logic [7:0] q);
    @(posedge mclk_i);
    cmd_o <= c;
    data_o <= d;
    {rd_o, wr_o, send_o} <= k;
    @(posedge mclk_i);
    {rd_o, wr_o, send_o} <= 3'b000;
    // released lines must not keep the old code
    cmd_o <= ~c;
    data_o <= ~d;
    #1;
    q = (rd_valid_i === k[2]) ? rd_data_i : 8'hXX;
  endtask : issue
endmodule : tsr_host_model
`default_nettype wire

/* verification/tsr_telemetry_status_regs_test.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// bench
// ****
module tsr_telemetry_status_regs_test;
  import tsr_pkg::*;
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic nop = 1'b0, ot = 1'b0, uv = 1'b0, rd, wr, sb, rv;
  logic [7:0] cmd, wdat, rdat, q;
  logic [8:0] vout = 9'h150;
  logic [7:0] vin_s = 8'hA5, iin_s = 8'h3C, iout_s = 8'h77, vfs;
  tsr_step_e step = TSR_STEP_5MV;
  int bad_count = 0;
  int checks = 0;
  always #25 mclk_i = ~mclk_i;
  tsr_host_model host (.mclk_i(mclk_i), .rd_data_i(rdat), .rd_valid_i(rv), .cmd_o(cmd),
    .rd_o(rd), .wr_o(wr), .send_o(sb), .data_o(wdat));
  tsr_telemetry_status_regs DUT (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .cmd_code_i(cmd),
    .rd_strobe_i(rd), .wr_strobe_i(wr), .send_byte_i(sb), .wr_data_i(wdat), .rd_data_o(rdat),
    .rd_valid_o(rv), .no_op_cycle_i(nop), .stage_overtemp_i(ot), .driver_supply_uv_i(uv),
    .vin_sample_i(vin_s), .iin_sample_i(iin_s), .vout_sample_i(vout), .iout_sample_i(iout_s),
    .vout_step_i(step), .vendor_fault_status_o(vfs));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic rd_exp(input logic [7:0] c, input logic [7:0] e);
    host.issue(c, 8'h00, 3'b100, q);
    chk(q, e);
  endtask : rd_exp
  task automatic end_of_test;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (3) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    rd_exp(CMD_INPUT_VOLTAGE, READING_RESET);
    rd_exp(CMD_INPUT_CURRENT, READING_RESET);
    // fast pair refreshes first, slow pair still at reset
    repeat (1950) @(posedge mclk_i);
    rd_exp(CMD_INPUT_CURRENT, 8'h3C);
    rd_exp(CMD_OUTPUT_CURRENT, 8'h77);
    rd_exp(CMD_INPUT_VOLTAGE, READING_RESET);
    repeat (1900) @(posedge mclk_i);
    rd_exp(CMD_INPUT_VOLTAGE, 8'hA5);
    rd_exp(CMD_OUTPUT_VOLTAGE, 8'hFF);
    @(posedge mclk_i);
    step <= TSR_STEP_10MV;
    vin_s <= 8'h5A;
    iin_s <= 8'h4D;
    iout_s <= 8'h2E;
    host.issue(CMD_INPUT_VOLTAGE, 8'h00, 3'b010, q);
    rd_exp(CMD_INPUT_VOLTAGE, 8'hA5);
    rd_exp(CMD_INPUT_CURRENT, 8'h3C);
    repeat (3800) @(posedge mclk_i);
    rd_exp(CMD_OUTPUT_VOLTAGE, 8'hA8);
    rd_exp(CMD_INPUT_VOLTAGE, 8'h5A);
    rd_exp(CMD_INPUT_CURRENT, 8'h4D);
    rd_exp(CMD_OUTPUT_CURRENT, 8'h2E);
    @(posedge mclk_i);
    nop <= 1'b1;
    uv <= 1'b1;
    @(posedge mclk_i);
    nop <= 1'b0;
    uv <= 1'b0;
    ot <= 1'b1;
    repeat (2) @(posedge mclk_i);
    rd_exp(CMD_VENDOR_STATUS, 8'h07);
    chk(vfs, 8'h07);
    host.issue(CMD_VENDOR_STATUS, 8'h01, 3'b010, q);
    rd_exp(CMD_VENDOR_STATUS, 8'h06);
    host.issue(CMD_FAULT_CLEAR, 8'h00, 3'b001, q);
    rd_exp(CMD_VENDOR_STATUS, 8'h02);
    @(posedge mclk_i);
    ot <= 1'b0;
    uv <= 1'b1;
    repeat (2) @(posedge mclk_i);
    host.issue(CMD_FAULT_CLEAR, 8'h00, 3'b001, q);
    rd_exp(CMD_VENDOR_STATUS, 8'h01);
    chk(vfs, 8'h01);
    rd_exp(8'h8A, UNMAPPED_READ);
    end_of_test();
  end
endmodule : tsr_telemetry_status_regs_test
`default_nettype wire
